// *** rtl/cmd_decoder_regs.svh ***
// register offsets, reset values and command codes of the command decoder
// Summary of operation
// R1: serial bytes are taken only while the chip select pin is low.
// R2: select low marks command and parameter bytes, high marks data bytes.
// R3: reset low returns every setting to its reset value.
// R4: host waits two frames between back to back one-column scroll commands.
// R5: host makes the scroll end column greater than the start column.
// R6: host makes the scroll end page not below the start page.
// R7: host sends scroll parameters three and five as dummies 01h and 00h.
// R8: codes 00h-0Fh load the low nibble of the page-mode column pointer.
// R9: codes 10h-1Fh load the high nibble of the page-mode column pointer.
// R10: 20h picks horizontal, vertical or page addressing; 11b refused.
// R11: command 21h sets column window start and end, reset 0 and 127.
// R12: command 22h sets page window start and end, reset 0 and 7.
// R13: codes B0h-B7h load the page pointer for page addressing.
// R14: codes 40h-7Fh load the display start line 0 to 63.
// R15: A0h maps column 0 to the first segment, A1h maps column 127.
// R16: A8h sets multiplex ratio N+1, reset 63, values 0 to 14 refused.
// R17: C0h scans rows forward, C8h scans them in reverse.
// R18: D3h sets the vertical row shift 0 to 63, reset zero.
// R19: DAh bit 4 picks row pin layout, bit 5 enables left/right remap.
// R20: DCh picks general-purpose pin mode, reset drive low.
// R21: D5h sets clock divide nibble and oscillator nibble, reset 0 and 7.
// R22: D9h sets both pre-charge phases 1 to 15, zero refused, reset 2.
// R23: DBh bits 5:2 set the row deselect level code, reset 1101b.
// R24: don't-care bits of commands and parameters are ignored.
// R25: parameters are counted in order and applied after the last arrives.
// R26: an invalid command value leaves its setting unchanged.
// R27: serial bits go msb first on rising clock, byte taken after bit eight.
`ifndef CMD_DECODER_REGS_SVH
`define CMD_DECODER_REGS_SVH
`define OFS_CTRL     8'h00
`define OFS_ADDR     8'h04
`define OFS_WIN      8'h08
`define OFS_DISP     8'h0C
`define OFS_TIME     8'h10
`define OFS_SCRL     8'h14
`define OFS_STAT     8'h18
`define RST_MODE     2'h2
`define MODE_BAD     2'h3
`define RST_COL_END  8'h7F
`define RST_PAGE_END 3'h7
`define RST_MUX      6'h3F
`define MUX_MIN      6'h0F
`define RST_GPIO     2'h2
`define RST_OSC      4'h7
`define RST_PRE      4'h2
`define RST_DESEL    4'hD
`define OP_MODE      8'h20
`define OP_COLWIN    8'h21
`define OP_PAGEWIN   8'h22
`define OP_SEG       8'hA0
`define OP_MUX       8'hA8
`define OP_SCAN      8'hC0
`define OP_OFFSET    8'hD3
`define OP_PINS      8'hDA
`define OP_GPIO      8'hDC
`define OP_CLK       8'hD5
`define OP_PRE       8'hD9
`define OP_DESEL     8'hDB
`define OP_SCRL      8'h2C
`define OP_PAGE      8'hB0
`define OP_CONTRAST  8'h81
`define OP_LOCK      8'hFD
`define OP_PUMP      8'h8D
`define OP_POWER     8'hD8
`define OP_IREF      8'hAD
`define OP_VAREA     8'hA3
`define OP_HSCRL     8'h26
`define OP_VSCRL     8'h29
`define OP_VSCRL_L   8'h2A
`endif

// *** rtl/cmd_decoder_pkg.sv ***
// types shared by the command decoder modules
package cmd_decoder_pkg;
	typedef enum logic {
		ST_OPCODE,
		ST_PARAM
	} dec_state_t;
	typedef logic [7:0] byte_t;
endpackage

// *** rtl/cmd_links.sv ***
// carriers between the decoder core, its serial receiver and its bus port
interface byte_link_if;
	logic                 valid;
	cmd_decoder_pkg::byte_t data;
	logic                 is_data;
	modport rx  (output valid, data, is_data);
	modport dec (input valid, data, is_data);
endinterface

interface reg_link_if;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic [31:0] rdata;
	logic        miss;
	modport bus  (output addr, wdata, wr, input rdata, miss);
	modport regs (input addr, wdata, wr, output rdata, miss);
endinterface

// *** rtl/serial_rx.sv ***
// four-wire serial byte receiver with pin synchronisers
module serial_rx (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic sin,
	input  wire logic dc,
	byte_link_if.rx   o
);
	// order: cs_n, sclk, sin, dc
	logic [3:0] s1_q, s2_q, s3_q, filt_q;
	logic       sclk_prev_q;
	logic [2:0] cnt_q;
	logic [6:0] sh_q;
	logic       rise;

	// a pin change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q   <= 4'h8;
			s2_q   <= 4'h8;
			s3_q   <= 4'h8;
			filt_q <= 4'h8;
		end else begin
			s1_q   <= {cs_n, sclk, sin, dc};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
		end
	end

	assign rise = filt_q[2] & ~sclk_prev_q;

	// R1: select gates bits
	// R27: msb first shifting
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			cnt_q       <= 3'h0;
			sh_q        <= 7'h00;
			o.valid     <= 1'b0;
			o.data      <= 8'h00;
			o.is_data   <= 1'b0;
		end else begin
			sclk_prev_q <= filt_q[2];
			o.valid     <= 1'b0;
			if (filt_q[3]) begin
				cnt_q <= 3'h0;
			end else if (rise) begin
				sh_q  <= {sh_q[5:0], filt_q[1]};
				cnt_q <= 3'(cnt_q + 3'h1);
				if (cnt_q == 3'h7) begin
					o.valid   <= 1'b1;
					o.data    <= {sh_q, filt_q[1]};
					o.is_data <= filt_q[0];
				end
			end
		end
	end
endmodule // serial_rx

// *** rtl/apb_port.sv ***
// apb slave port with one wait state
module apb_port (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	reg_link_if.bus          r
);
	logic access;

	assign access  = psel & penable & ~pready;
	assign r.addr  = paddr;
	assign r.wdata = pwdata;
	// write lands at the completing edge only
	assign r.wr    = psel & penable & pwrite & pready;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= access;
			if (access) begin
				prdata  <= pwrite ? 32'h0 : r.rdata;
				pslverr <= r.miss;
			end
		end
	end
endmodule // apb_port

// *** rtl/cmd_decoder.sv ***
// display command decoder: serial command link, settings, apb status port
//
// Local design decisions: the APB slave port and the register addresses.
`include "cmd_decoder_regs.svh"

module cmd_decoder (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CS_N,
	input  wire logic        DC_SEL,
	input  wire logic        SCLK,
	input  wire logic        SERIAL_IN,
	input  wire logic        GPIO_IN,
	output logic             GPIO_OUT,
	output logic             GPIO_OE,
	output logic             RAM_WE,
	output logic      [7:0]  RAM_DATA
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	byte_link_if rx_link ();
	reg_link_if  reg_link ();

	cmd_decoder_pkg::dec_state_t state_q;
	cmd_decoder_pkg::byte_t      op_q;
	cmd_decoder_pkg::byte_t      prm_q [0:6];
	cmd_decoder_pkg::byte_t      full [0:6];
	logic [2:0]  idx_q;
	logic [2:0]  need_q;
	logic        enable_q;
	logic        cmd_byte;
	logic        cmd_go;
	logic        prm_go;
	cmd_decoder_pkg::byte_t      b;

	logic [3:0]  col_lo_q;
	logic [3:0]  col_hi_q;
	logic [2:0]  page_q;
	logic [1:0]  mode_q;
	logic [7:0]  col_start_q;
	logic [7:0]  col_end_q;
	logic [2:0]  page_start_q;
	logic [2:0]  page_end_q;
	logic [5:0]  start_line_q;
	logic        seg_remap_q;
	logic        scan_rev_q;
	logic [5:0]  mux_q;
	logic [5:0]  row_shift_q;
	logic        pin_alt_q;
	logic        lr_remap_q;
	logic [1:0]  gpio_mode_q;
	logic [3:0]  clk_div_q;
	logic [3:0]  osc_q;
	logic [3:0]  pre1_q;
	logic [3:0]  pre2_q;
	logic [3:0]  deselect_q;
	logic        scrl_dir_q;
	logic        scrl_set_q;
	logic [2:0]  scrl_start_page_q;
	logic [2:0]  scrl_end_page_q;
	logic [7:0]  scrl_start_col_q;
	logic [7:0]  scrl_end_col_q;
	logic [7:0]  last_data_q;
	logic [15:0] data_cnt_q;
	logic [2:0]  gsync_q;
	logic        gpio_filt_q;
	logic        gpio_seen_q;

	// ------------------------------------------------------------
	// parameter count of each command code
	// ------------------------------------------------------------
	// codes outside this block still consume their bytes, so that a
	// foreign parameter is never mistaken for a command
	function automatic logic [2:0] param_count(input logic [7:0] op);
		logic [2:0] n;
		n = 3'h0;
		case (op)
			`OP_MODE, `OP_MUX, `OP_OFFSET, `OP_PINS, `OP_GPIO,
			`OP_CLK, `OP_PRE, `OP_DESEL, `OP_CONTRAST, `OP_LOCK,
			`OP_PUMP, `OP_POWER, `OP_IREF:
				n = 3'h1;
			`OP_COLWIN, `OP_PAGEWIN, `OP_VAREA:
				n = 3'h2;
			`OP_SCRL, `OP_SCRL | 8'h01, `OP_HSCRL, `OP_HSCRL | 8'h01,
			`OP_VSCRL, `OP_VSCRL_L:
				n = 3'h7;
			default:
				n = 3'h0;
		endcase
		return n;
	endfunction

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	serial_rx u_rx (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.cs_n  (CS_N),
		.sclk  (SCLK),
		.sin   (SERIAL_IN),
		.dc    (DC_SEL),
		.o     (rx_link)
	);

	apb_port u_apb (
		.clk     (MCLK),
		.rst_n   (RESET_N),
		.psel    (PSEL),
		.penable (PENABLE),
		.pwrite  (PWRITE),
		.paddr   (PADDR),
		.pwdata  (PWDATA),
		.prdata  (PRDATA),
		.pready  (PREADY),
		.pslverr (PSLVERR),
		.r       (reg_link)
	);

	// ------------------------------------------------------------
	// byte routing and command sequencing
	// ------------------------------------------------------------
	assign b = rx_link.data;
	// R2: select low routes to decoder
	assign cmd_byte = rx_link.valid & ~rx_link.is_data & enable_q;
	assign cmd_go   = cmd_byte & (state_q == cmd_decoder_pkg::ST_OPCODE);
	// R25: apply on final parameter
	assign prm_go   = cmd_byte & (state_q == cmd_decoder_pkg::ST_PARAM)
		& (idx_q == 3'(need_q - 3'h1));

	// the final byte is applied in the cycle it arrives
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			full[i] = (3'(i) == idx_q) ? b : prm_q[i];
		end
	end

	// R25: count parameters
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			state_q <= cmd_decoder_pkg::ST_OPCODE;
			op_q    <= 8'h00;
			idx_q   <= 3'h0;
			need_q  <= 3'h0;
		end else if (cmd_byte) begin
			unique case (state_q)
				cmd_decoder_pkg::ST_OPCODE: begin
					if (param_count(b) != 3'h0) begin
						op_q    <= b;
						need_q  <= param_count(b);
						idx_q   <= 3'h0;
						state_q <= cmd_decoder_pkg::ST_PARAM;
					end
				end
				cmd_decoder_pkg::ST_PARAM: begin
					idx_q <= 3'(idx_q + 3'h1);
					if (prm_go) begin
						state_q <= cmd_decoder_pkg::ST_OPCODE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < 7; i++) begin
				prm_q[i] <= 8'h00;
			end
		end else if (cmd_byte && state_q == cmd_decoder_pkg::ST_PARAM) begin
			prm_q[idx_q] <= b;
		end
	end

	// R2: display data goes to ram port
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			RAM_WE      <= 1'b0;
			RAM_DATA    <= 8'h00;
			last_data_q <= 8'h00;
			data_cnt_q  <= 16'h0000;
		end else begin
			RAM_WE <= rx_link.valid & rx_link.is_data & enable_q;
			if (rx_link.valid & rx_link.is_data & enable_q) begin
				RAM_DATA    <= b;
				last_data_q <= b;
				data_cnt_q  <= 16'(data_cnt_q + 16'h0001);
			end
		end
	end

	// ------------------------------------------------------------
	// addressing settings
	// ------------------------------------------------------------
	// R3: reset values
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			col_lo_q <= 4'h0;
			col_hi_q <= 4'h0;
			page_q   <= 3'h0;
			mode_q   <= `RST_MODE;
		end else begin
			// R8: low column nibble
			if (cmd_go && b[7:4] == 4'h0) begin
				col_lo_q <= b[3:0];
			end
			// R9: high column nibble
			if (cmd_go && b[7:4] == 4'h1) begin
				col_hi_q <= b[3:0];
			end
			// R13: page pointer
			if (cmd_go && b[7:3] == 5'(`OP_PAGE >> 3)) begin
				page_q <= b[2:0];
			end
			// R10: addressing mode, R26 refuses 11b
			if (prm_go && op_q == `OP_MODE && full[0][1:0] != `MODE_BAD) begin
				mode_q <= full[0][1:0];
			end
		end
	end

	// R11: column window
	// R12: page window
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			col_start_q  <= 8'h00;
			col_end_q    <= `RST_COL_END;
			page_start_q <= 3'h0;
			page_end_q   <= `RST_PAGE_END;
		end else if (prm_go) begin
			if (op_q == `OP_COLWIN) begin
				col_start_q <= full[0];
				col_end_q   <= full[1];
			end
			// R24: only low three bits
			if (op_q == `OP_PAGEWIN) begin
				page_start_q <= full[0][2:0];
				page_end_q   <= full[1][2:0];
			end
		end
	end

	// ------------------------------------------------------------
	// panel layout settings
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			start_line_q <= 6'h00;
			seg_remap_q  <= 1'b0;
			scan_rev_q   <= 1'b0;
		end else if (cmd_go) begin
			// R14: start line
			if (b[7:6] == 2'h1) begin
				start_line_q <= b[5:0];
			end
			// R15: segment remap
			if (b[7:1] == 7'(`OP_SEG >> 1)) begin
				seg_remap_q <= b[0];
			end
			// R17: row scan direction
			if ((b & 8'hF7) == `OP_SCAN) begin
				scan_rev_q <= b[3];
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			mux_q       <= `RST_MUX;
			row_shift_q <= 6'h00;
			pin_alt_q   <= 1'b1;
			lr_remap_q  <= 1'b0;
		end else if (prm_go) begin
			// R16: multiplex ratio, R26 refuses small values
			if (op_q == `OP_MUX && full[0][5:0] >= `MUX_MIN) begin
				mux_q <= full[0][5:0];
			end
			// R18: row shift
			if (op_q == `OP_OFFSET) begin
				row_shift_q <= full[0][5:0];
			end
			// R19: row pin layout
			if (op_q == `OP_PINS) begin
				pin_alt_q  <= full[0][4];
				lr_remap_q <= full[0][5];
			end
		end
	end

	// ------------------------------------------------------------
	// timing and drive settings
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			clk_div_q   <= 4'h0;
			osc_q       <= `RST_OSC;
			pre1_q      <= `RST_PRE;
			pre2_q      <= `RST_PRE;
			deselect_q  <= `RST_DESEL;
			gpio_mode_q <= `RST_GPIO;
		end else if (prm_go) begin
			// R21: divider and oscillator
			if (op_q == `OP_CLK) begin
				clk_div_q <= full[0][3:0];
				osc_q     <= full[0][7:4];
			end
			// R22: pre-charge, R26 zero phase kept
			if (op_q == `OP_PRE && full[0][3:0] != 4'h0) begin
				pre1_q <= full[0][3:0];
			end
			if (op_q == `OP_PRE && full[0][7:4] != 4'h0) begin
				pre2_q <= full[0][7:4];
			end
			// R23: deselect level
			if (op_q == `OP_DESEL) begin
				deselect_q <= full[0][5:2];
			end
			// R20: pin mode
			if (op_q == `OP_GPIO) begin
				gpio_mode_q <= full[0][1:0];
			end
		end
	end

	// R20: pin drive from mode
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			GPIO_OE  <= 1'b0;
			GPIO_OUT <= 1'b0;
		end else begin
			GPIO_OE  <= gpio_mode_q[1];
			GPIO_OUT <= gpio_mode_q[1] & gpio_mode_q[0];
		end
	end

	// pin level is only captured while its input is enabled
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			gsync_q     <= 3'h0;
			gpio_filt_q <= 1'b0;
			gpio_seen_q <= 1'b0;
		end else begin
			gsync_q <= {gsync_q[1:0], GPIO_IN};
			if (gsync_q[1] == gsync_q[2]) begin
				gpio_filt_q <= gsync_q[2];
			end
			if (gpio_mode_q == 2'h1) begin
				gpio_seen_q <= gpio_filt_q;
			end
		end
	end

	// ------------------------------------------------------------
	// content scroll setup
	// ------------------------------------------------------------
	// R7: dummy bytes ignored
	// R5: R6: host ordering trusted, stored as sent
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			scrl_dir_q        <= 1'b0;
			scrl_set_q        <= 1'b0;
			scrl_start_page_q <= 3'h0;
			scrl_end_page_q   <= 3'h0;
			scrl_start_col_q  <= 8'h00;
			scrl_end_col_q    <= `RST_COL_END;
		end else if (prm_go && op_q[7:1] == 7'(`OP_SCRL >> 1)) begin
			scrl_dir_q        <= op_q[0];
			scrl_set_q        <= 1'b1;
			scrl_start_page_q <= full[1][2:0];
			scrl_end_page_q   <= full[3][2:0];
			scrl_start_col_q  <= full[5];
			scrl_end_col_q    <= full[6];
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	// stopping the decoder drops bytes rather than queueing them
	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			enable_q <= 1'b1;
		end else if (reg_link.wr && reg_link.addr == `OFS_CTRL) begin
			enable_q <= reg_link.wdata[0];
		end
	end

	always_comb begin
		reg_link.rdata = 32'h0;
		reg_link.miss  = 1'b0;
		case (reg_link.addr)
			`OFS_CTRL: reg_link.rdata = {31'h0, enable_q};
			`OFS_ADDR: reg_link.rdata = {18'h0, mode_q, 1'b0, page_q,
				col_hi_q, col_lo_q};
			`OFS_WIN:  reg_link.rdata = {9'h0, page_end_q, 1'b0,
				page_start_q, col_end_q, col_start_q};
			`OFS_DISP: reg_link.rdata = {6'h0, lr_remap_q, pin_alt_q,
				2'h0, row_shift_q, 2'h0, mux_q, scan_rev_q,
				seg_remap_q, start_line_q};
			`OFS_TIME: reg_link.rdata = {7'h0, gpio_seen_q, 2'h0,
				gpio_mode_q, deselect_q, pre2_q, pre1_q, osc_q,
				clk_div_q};
			`OFS_SCRL: reg_link.rdata = {scrl_end_col_q,
				scrl_start_col_q, 5'h0, scrl_end_page_q, 1'b0,
				scrl_start_page_q, 2'h0, scrl_set_q, scrl_dir_q};
			`OFS_STAT: reg_link.rdata = {data_cnt_q, last_data_q, 1'b0,
				need_q, idx_q, state_q == cmd_decoder_pkg::ST_PARAM};
			default:   reg_link.miss = 1'b1;
		endcase
	end
endmodule // cmd_decoder

// *** testbench/cmd_decoder_checker.sv ***
// port assertions for the command decoder
module cmd_decoder_checker (
	input wire logic        MCLK,
	input wire logic        RESET_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        CS_N,
	input wire logic        GPIO_OUT,
	input wire logic        GPIO_OE,
	input wire logic        RAM_WE,
	input wire logic [7:0]  RAM_DATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] idle_q;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// ----------------
	// helper logic
	// ----------------
	// a byte may still land just after the select rises, hence the margin
	always_ff @(posedge MCLK) begin
		if (!RESET_N || !CS_N) begin
			idle_q <= 5'h00;
		end else if (idle_q != 5'h1F) begin
			idle_q <= idle_q + 5'h01;
		end
	end
	sequence setup_s; PSEL && !PENABLE; endsequence
	sequence access_s; PSEL && PENABLE; endsequence
	// ----------------
	// assertions
	// ----------------
	reset_quiet_a: assert property ($rose(RESET_N) |->
		!PREADY && !RAM_WE && PRDATA == 32'h0 && RAM_DATA == 8'h00)
		else $error("outputs not quiet after reset");
	gpio_reset_a: assert property ($rose(RESET_N) |=>
		GPIO_OE && !GPIO_OUT) else $error("gpio not driving low");
	ready_wait_a: assert property (setup_s ##1 access_s |->
		!PREADY ##1 PREADY) else $error("bus answer not after one wait");
	bad_addr_a: assert property (PREADY && PADDR >= 8'h1C |->
		PSLVERR && PRDATA == 32'h0) else $error("unmapped not refused");
	ram_pulse_a: assert property (RAM_WE |=> !RAM_WE)
		else $error("ram strobe longer than one cycle");
	data_follow_a: assert property ($changed(RAM_DATA) |->
		##[0:1] RAM_WE) else $error("ram data moved without strobe");
	idle_link_a: assert property (idle_q > 5'h14 |-> !RAM_WE)
		else $error("byte taken while deselected");
	gpio_drive_a: assert property (GPIO_OUT |-> GPIO_OE)
		else $error("gpio high level while not driving");
endmodule // cmd_decoder_checker

bind cmd_decoder cmd_decoder_checker chk (.MCLK(MCLK), .RESET_N(RESET_N),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .CS_N(CS_N), .GPIO_OUT(GPIO_OUT),
	.GPIO_OE(GPIO_OE), .RAM_WE(RAM_WE), .RAM_DATA(RAM_DATA));

// *** testbench/serial_host.sv ***
// host side model of the four-wire serial command link
module serial_host (
	input wire logic clk,
	output logic     cs_n,
	output logic     sclk,
	output logic     sin,
	output logic     dc
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sin = 1'b1;
		dc = 1'b0;
	end
	// ----------------
	// byte transfer
	// ----------------
	// six cycles a phase keeps both clock phases above 50 ns
	task automatic send_byte(input logic sel, input logic d_c,
		input logic [7:0] b);
		int i;
		@(posedge clk);
		cs_n <= !sel;
		dc <= d_c;
		for (i = 7; i >= 0; i--) begin
			sin <= b[i];
			repeat (6) @(posedge clk);
			sclk <= 1'b1;
			repeat (6) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (6) @(posedge clk);
		// released line shows the inverse of its last bit
		sin <= !b[0];
		cs_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
endmodule // serial_host

// *** testbench/display_command_decoder_bench.sv ***
// self-checking bench for the command decoder
module display_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, ram_data;
	logic [31:0] pwdata, prdata, rd;
	logic        cs_n, dc_sel, sclk, serial_in, gpio_in, gpio_out;
	logic        gpio_oe, ram_we, er;
	int          err_total, checked;
	cmd_decoder DUT (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CS_N(cs_n), .DC_SEL(dc_sel), .SCLK(sclk),
		.SERIAL_IN(serial_in), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
		.GPIO_OE(gpio_oe), .RAM_WE(ram_we), .RAM_DATA(ram_data));
	serial_host host (.clk(mclk), .cs_n(cs_n), .sclk(sclk),
		.sin(serial_in), .dc(dc_sel));
	// ----------------
	// shared tasks
	// ----------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic cmds(input cmd_decoder_pkg::byte_t l[$]);
		foreach (l[i])
			host.send_byte(1'b1, 1'b0, l[i]);
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset();
		chk({30'h0, gpio_oe, gpio_out}, 32'h2);
		rdchk(8'h00, 32'h00000001);
		rdchk(8'h04, 32'h00002000);
		rdchk(8'h08, 32'h00707F00);
		rdchk(8'h0C, 32'h01003F00);
		rdchk(8'h10, 32'h002D2270);
		rdchk(8'h14, 32'h7F000000);
		rdchk(8'h18, 32'h00000000);
		$display("test reset done");
	endtask
	task automatic t_single();
		cmds({8'h05, 8'h1A, 8'hB3, 8'h6A, 8'hA1, 8'hC8});
		rdchk(8'h04, 32'h000023A5);
		rdchk(8'h0C, 32'h01003FEA);
		$display("test single done");
	endtask
	task automatic t_multi();
		host.send_byte(1'b1, 1'b0, 8'h21);
		host.send_byte(1'b1, 1'b1, 8'h5C);
		cmds({8'h10, 8'h70, 8'h20, 8'h00});
		rdchk(8'h04, 32'h000003A5);
		cmds({8'h20, 8'h01, 8'h20, 8'hFF, 8'h22, 8'hFA, 8'h0D});
		rdchk(8'h04, 32'h000013A5);
		rdchk(8'h08, 32'h00527010);
		chk({24'h0, ram_data}, 32'h5C);
		$display("test multi done");
	endtask
	task automatic t_params();
		cmds({8'hA8, 8'hDF, 8'hA8, 8'h0E, 8'hD3, 8'hFF, 8'hDA, 8'h22});
		cmds({8'hD5, 8'hF3, 8'hD9, 8'h30, 8'hDB, 8'hFF});
		rdchk(8'h0C, 32'h023F1FEA);
		$display("test params done");
	endtask
	task automatic t_gpio();
		int m;
		gpio_in <= 1'b1;
		for (m = 0; m < 4; m++) begin
			cmds({8'hDC, 8'(m)});
			chk({31'h0, gpio_oe}, {31'h0, m[1]});
			if (m[1])
				chk({31'h0, gpio_out}, {31'h0, m[0]});
			apb(1'b0, 8'h10, 32'h0);
			chk(rd & 32'h01000000, (m > 0) ? 32'h01000000 : 32'h0);
		end
		rdchk(8'h10, 32'h013F32F3);
		$display("test gpio done");
	endtask
	task automatic t_link();
		host.send_byte(1'b0, 1'b1, 8'h99);
		host.send_byte(1'b0, 1'b0, 8'hB7);
		apb(1'b1, 8'h00, 32'h0);
		cmds({8'hB1});
		apb(1'b1, 8'h00, 32'h1);
		rdchk(8'h04, 32'h000013A5);
		apb(1'b1, 8'h18, 32'h0);
		chk({31'h0, er}, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(rd & 32'hFFFFFF00, 32'h00015C00);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test link done");
	endtask
	task automatic t_scroll();
		cmds({8'h2C, 8'h00, 8'h02, 8'h01});
		cmds({8'h05, 8'h00, 8'h10, 8'h40});
		rdchk(8'h14, 32'h40100522);
		$display("test scroll done");
	endtask
	// a foreign command's parameter must not be taken as a page command
	task automatic t_left();
		cmds({8'h81, 8'hB5, 8'h2D, 8'h00, 8'h07, 8'h01});
		cmds({8'h07, 8'h00, 8'h00, 8'h7F});
		rdchk(8'h14, 32'h7F000773);
		rdchk(8'h04, 32'h00002000);
		$display("test left scroll done");
	endtask
	// ----------------
	// run
	// ----------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (60000) @(posedge mclk);
		err_total++;
		final_report();
	end
	initial begin
		{reset_n, psel, penable, pwrite, gpio_in} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		checked = 0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_single();
		t_multi();
		t_params();
		t_gpio();
		t_link();
		t_scroll();
		reset_n <= 1'b0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_left();
		final_report();
	end
endmodule // display_command_decoder_bench
